// ==== src/mcr_pkg.sv ====
// Purpose: Shared constants for the magnetometer configuration link.
// Assumes: core_clk at 20 MHz; serial link in standard mode.
// Notes: Used by the device end, the host end and the testbench.
// Operation
// - 8-bit register address selects accessed register
// - Slave address bytes 3Ch write, 3Dh read
// - Rate and bias at 00h, gain at 01h
// - Register bytes shifted most significant first
// - Host clears top three bits of 00h
// - Rate field paces all result updates together
// - Codes 000-110 give 0.75-75 Hz; 111 unused
// - Bias codes: 00 normal, 01 positive, 10 negative
// - Bias field applies or omits sensor bias
// - One gain field for all channels
// - Host clears non-gain bits of 01h
// - Results clamped to 12-bit span, two bytes
package mcr_pkg;
	localparam int unsigned CORE_CLK_HZ   = 20_000_000;
	localparam int unsigned CLK_PERIOD_NS = 50;

	// Link addressing and register map.
	localparam logic [7:0] SLV_ADDR_WR   = 8'h3c;
	localparam logic [7:0] SLV_ADDR_RD   = 8'h3d;
	localparam logic [7:0] REG_RATE_BIAS = 8'h00;
	localparam logic [7:0] REG_GAIN      = 8'h01;
	localparam logic [7:0] REG_OUT_XH    = 8'h03;
	localparam logic [7:0] REG_OUT_XL    = 8'h04;
	localparam logic [7:0] REG_OUT_YH    = 8'h05;
	localparam logic [7:0] REG_OUT_YL    = 8'h06;
	localparam logic [7:0] REG_OUT_ZH    = 8'h07;
	localparam logic [7:0] REG_OUT_ZL    = 8'h08;

	// Field layout and values after reset.
	localparam int         RATE_LSB       = 2;
	localparam int         BIAS_LSB       = 0;
	localparam int         GAIN_LSB       = 5;
	localparam logic [7:0] RATE_BIAS_MASK = 8'h1f;
	localparam logic [7:0] GAIN_MASK      = 8'he0;
	localparam logic [7:0] RATE_BIAS_RST  = 8'h10;
	localparam logic [7:0] GAIN_RST       = 8'h20;
	localparam logic [2:0] RATE_UNUSED    = 3'h7;
	localparam logic [1:0] BIAS_POS       = 2'h1;
	localparam logic [1:0] BIAS_NEG       = 2'h2;
	localparam logic [1:0] BIAS_UNUSED    = 2'h3;

	// Minimum output rates in millihertz for codes 0 to 6.
	localparam int unsigned RATE_MILLIHZ [0:6] = '{750, 1500, 3000, 7500, 15000, 30000, 75000};

	// Result span.
	localparam logic signed [15:0] OUT_MIN = 16'hf800;
	localparam logic signed [15:0] OUT_MAX = 16'h07ff;

	// Serial clock quarter period, least time rounded up.
	localparam int unsigned SCL_QTR_NS  = 2500;
	localparam int unsigned SCL_QTR_CYC = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Host register map on APB.
	localparam logic [7:0] HOFS_CMD      = 8'h00;
	localparam logic [7:0] HOFS_REG      = 8'h04;
	localparam logic [7:0] HOFS_WDATA    = 8'h08;
	localparam logic [7:0] HOFS_STATUS   = 8'h0c;
	localparam int         CMD_GO_BIT    = 0;
	localparam int         CMD_READ_BIT  = 1;
	localparam int         ST_RDATA_LSB  = 8;
endpackage

// ==== src/mcr_link_if.sv ====
// Purpose: Open-drain serial link between host end and device end.
// Assumes: Pull-ups on both lines; enables are active low.
// Notes: Wire levels are resolved here from the enables.
interface mcr_link_if;
	logic host_scl_oe_n;	// Host pulls clock low when low.
	logic host_scl_o;	// Host clock drive value.
	logic host_sda_oe_n;	// Host pulls data low when low.
	logic host_sda_o;	// Host data drive value.
	logic dev_sda_oe_n;	// Device pulls data low when low.
	logic dev_sda_o;	// Device data drive value.
	logic scl;		// Resolved clock line.
	logic sda;		// Resolved data line.

	// Wired-AND with pull-up on each line.
	assign scl = host_scl_oe_n ? 1'b1 : host_scl_o;
	assign sda = (host_sda_oe_n ? 1'b1 : host_sda_o) & (dev_sda_oe_n ? 1'b1 : dev_sda_o);

	modport host (output host_scl_oe_n, host_scl_o, host_sda_oe_n, host_sda_o, input scl, sda);
	modport dev (output dev_sda_oe_n, dev_sda_o, input scl, sda);
endinterface

// ==== src/mcr_dev.sv ====
// Purpose: Device end: serial slave holding rate, bias and gain settings.
// Assumes: Link lines come from another domain and are filtered here.
// Notes: Register pointer advances after each data byte, read or write.
module mcr_dev import mcr_pkg::*; #(
	parameter int unsigned CORE_HZ = CORE_CLK_HZ	// Lower to shorten rate periods.
) (
	input  wire logic               core_clk,		// Core clock.
	input  wire logic               reset_n,		// Synchronous reset, low.
	mcr_link_if.dev                 link,		// Serial link.
	input  wire logic signed [15:0] meas_x,		// Raw X result.
	input  wire logic signed [15:0] meas_y,		// Raw Y result.
	input  wire logic signed [15:0] meas_z,		// Raw Z result.
	output logic [2:0]              output_rate_sel,	// Rate code.
	output logic [1:0]              bias_meas_sel,	// Bias code.
	output logic [2:0]              gain_sel,		// Common gain code.
	output logic                    bias_pos_en,	// Apply positive bias.
	output logic                    bias_neg_en,	// Apply negative bias.
	output logic                    result_tick	// Results latched.
);
	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_ADDR = 3'b001,
		D_REGA = 3'b010,
		D_WDAT = 3'b011,
		D_ACK  = 3'b100,
		D_TX   = 3'b101,
		D_MACK = 3'b110
	} mcr_dstate_type;

	typedef struct packed {
		mcr_dstate_type state;
		mcr_dstate_type after;
		logic [3:0]     cnt;
		logic [7:0]     sh;
		logic [7:0]     ptr;
		logic           more;
		logic [7:0]     cra;
		logic [7:0]     crb;
		logic [15:0]    out_x;
		logic [15:0]    out_y;
		logic [15:0]    out_z;
		logic [31:0]    rate_cnt;
		logic           tick;
		logic           bias_pos;
		logic           bias_neg;
		logic           sda_oe_n;
		logic [2:0]     scl_sy;
		logic [2:0]     sda_sy;
		logic           scl_f;
		logic           sda_f;
	} mcr_dev_st_type;

	mcr_dev_st_type s_r;
	mcr_dev_st_type s_nxt;
	logic           scl_rise;
	logic           scl_fall;
	logic           bus_start;
	logic           bus_stop;
	logic [7:0]     rd_val;

	// Period in cycles of one rate code; longest time, so it rounds down.
	function automatic logic [31:0] rate_cyc(input logic [2:0] code);
		longint c;
		c = (longint'(CORE_HZ) * 1000) / longint'(RATE_MILLIHZ[code]);
		return (c < 1) ? 32'h0000_0001 : c[31:0];
	endfunction

	// Keeps a result inside the span the output registers may hold.
	function automatic logic [15:0] clamp(input logic signed [15:0] v);
		if (v < OUT_MIN) begin
			return OUT_MIN;
		end
		if (v > OUT_MAX) begin
			return OUT_MAX;
		end
		return v;
	endfunction

	// Byte seen by a read at the current pointer; holes read as zero.
	function automatic logic [7:0] rd_byte(input mcr_dev_st_type s);
		case (s.ptr)
			REG_RATE_BIAS: return s.cra;
			REG_GAIN:      return s.crb;
			REG_OUT_XH:    return s.out_x[15:8];
			REG_OUT_XL:    return s.out_x[7:0];
			REG_OUT_YH:    return s.out_y[15:8];
			REG_OUT_YL:    return s.out_y[7:0];
			REG_OUT_ZH:    return s.out_z[15:8];
			REG_OUT_ZL:    return s.out_z[7:0];
			default:       return 8'h00;
		endcase
	endfunction

	// Next state: pin filters, link protocol, register file and rate timer.
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		s_nxt.scl_sy = {s_r.scl_sy[1:0], link.scl};
		s_nxt.sda_sy = {s_r.sda_sy[1:0], link.sda};
		// A line change counts only once the last two stages agree.
		if (s_r.scl_sy[1] == s_r.scl_sy[2]) begin
			s_nxt.scl_f = s_r.scl_sy[2];
		end
		if (s_r.sda_sy[1] == s_r.sda_sy[2]) begin
			s_nxt.sda_f = s_r.sda_sy[2];
		end
		scl_rise = s_nxt.scl_f & ~s_r.scl_f;
		scl_fall = ~s_nxt.scl_f & s_r.scl_f;
		bus_start = s_r.scl_f & s_nxt.scl_f & s_r.sda_f & ~s_nxt.sda_f;
		bus_stop = s_r.scl_f & s_nxt.scl_f & ~s_r.sda_f & s_nxt.sda_f;
		rd_val = rd_byte(s_r);

		// Start and stop override any transfer in progress.
		if (bus_start) begin
			s_nxt.state = D_ADDR;
			s_nxt.cnt = 4'h0;
			s_nxt.sda_oe_n = 1'b1;
		end else if (bus_stop) begin
			s_nxt.state = D_IDLE;
			s_nxt.sda_oe_n = 1'b1;
		end else begin
			unique case (s_r.state)
				D_IDLE: begin
				end
				D_ADDR, D_REGA, D_WDAT: begin
					if (scl_rise) begin
						s_nxt.sh = {s_r.sh[6:0], s_r.sda_f};
						s_nxt.cnt = s_r.cnt + 4'h1;
					end else if (scl_fall && s_r.cnt == 4'h8) begin
						s_nxt.sda_oe_n = 1'b0;
						s_nxt.state = D_ACK;
						s_nxt.cnt = 4'h0;
						if (s_r.state == D_ADDR) begin
							if (s_r.sh == SLV_ADDR_WR) begin
								s_nxt.after = D_REGA;
							end else if (s_r.sh == SLV_ADDR_RD) begin
								s_nxt.after = D_TX;
							end else begin
								s_nxt.sda_oe_n = 1'b1;
								s_nxt.state = D_IDLE;
							end
						end else if (s_r.state == D_REGA) begin
							s_nxt.ptr = s_r.sh;
							s_nxt.after = D_WDAT;
						end else begin
							// Only the defined fields are stored.
							if (s_r.ptr == REG_RATE_BIAS) begin
								s_nxt.cra = s_r.sh & RATE_BIAS_MASK;
								s_nxt.rate_cnt = 32'h0;
							end
							if (s_r.ptr == REG_GAIN) begin
								s_nxt.crb = s_r.sh & GAIN_MASK;
							end
							s_nxt.ptr = s_r.ptr + 8'h01;
							s_nxt.after = D_WDAT;
						end
					end
				end
				D_ACK: begin
					// The acknowledge ends at the falling edge of its clock.
					if (scl_fall) begin
						s_nxt.state = s_r.after;
						s_nxt.cnt = 4'h0;
						s_nxt.sda_oe_n = 1'b1;
						if (s_r.after == D_TX) begin
							s_nxt.sh = rd_val;
							s_nxt.sda_oe_n = rd_val[7];
							s_nxt.ptr = s_r.ptr + 8'h01;
						end
					end
				end
				D_TX: begin
					if (scl_rise) begin
						s_nxt.cnt = s_r.cnt + 4'h1;
					end else if (scl_fall) begin
						if (s_r.cnt == 4'h8) begin
							s_nxt.sda_oe_n = 1'b1;
							s_nxt.state = D_MACK;
						end else begin
							s_nxt.sda_oe_n = s_r.sh[6];
							s_nxt.sh = {s_r.sh[6:0], 1'b0};
						end
					end
				end
				D_MACK: begin
					// A low acknowledge asks for another byte; high ends the read.
					if (scl_rise) begin
						s_nxt.more = ~s_r.sda_f;
					end else if (scl_fall) begin
						s_nxt.cnt = 4'h0;
						if (s_r.more) begin
							s_nxt.state = D_TX;
							s_nxt.sh = rd_val;
							s_nxt.sda_oe_n = rd_val[7];
							s_nxt.ptr = s_r.ptr + 8'h01;
						end else begin
							s_nxt.state = D_IDLE;
						end
					end
				end
				default: begin
					s_nxt.state = D_IDLE;
					s_nxt.sda_oe_n = 1'b1;
				end
			endcase
		end

		// Unused rate code holds the timer, so no results are latched.
		if (s_r.cra[RATE_LSB +: 3] == RATE_UNUSED) begin
			s_nxt.rate_cnt = 32'h0;
		end else if (s_r.rate_cnt + 32'h1 >= rate_cyc(s_r.cra[RATE_LSB +: 3])) begin
			s_nxt.rate_cnt = 32'h0;
			s_nxt.tick = 1'b1;
			s_nxt.out_x = clamp(meas_x);
			s_nxt.out_y = clamp(meas_y);
			s_nxt.out_z = clamp(meas_z);
		end else if (s_nxt.rate_cnt == s_r.rate_cnt) begin
			s_nxt.rate_cnt = s_r.rate_cnt + 32'h1;
		end

		// Unused bias code applies no bias at all.
		s_nxt.bias_pos = (s_r.cra[BIAS_LSB +: 2] == BIAS_POS);
		s_nxt.bias_neg = (s_r.cra[BIAS_LSB +: 2] == BIAS_NEG);
	end

	// State register.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			s_r <= '0;
			s_r.cra <= RATE_BIAS_RST;
			s_r.crb <= GAIN_RST;
			s_r.sda_oe_n <= 1'b1;
			s_r.scl_sy <= 3'h7;
			s_r.sda_sy <= 3'h7;
			s_r.scl_f <= 1'b1;
			s_r.sda_f <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs come straight from the state register; the device data drive value is tied low.
	assign output_rate_sel = s_r.cra[RATE_LSB +: 3];
	assign bias_meas_sel = s_r.cra[BIAS_LSB +: 2];
	assign gain_sel = s_r.crb[GAIN_LSB +: 3];
	assign bias_pos_en = s_r.bias_pos;
	assign bias_neg_en = s_r.bias_neg;
	assign result_tick = s_r.tick;
	assign link.dev_sda_oe_n = s_r.sda_oe_n;
	assign link.dev_sda_o = 1'b0;
endmodule

// ==== src/mcr_host.sv ====
// Purpose: Host end: serial master driven from APB command registers.
// Assumes: Single master on the link; the device never stretches the clock.
// Notes: One register write or one single-byte read per command.
module mcr_host import mcr_pkg::*; #(
	parameter int unsigned QTR_CYC = SCL_QTR_CYC	// Cycles per clock quarter.
) (
	input  wire logic        core_clk,	// Core clock.
	input  wire logic        reset_n,	// Synchronous reset, low.
	input  wire logic        psel,	// APB select.
	input  wire logic        penable,	// APB enable.
	input  wire logic        pwrite,	// APB direction.
	input  wire logic [7:0]  paddr,	// APB byte address.
	input  wire logic [31:0] pwdata,	// APB write data.
	output logic [31:0]      prdata,	// APB read data.
	output logic             pready,	// APB ready.
	output logic             pslverr,	// APB error, unmapped.
	mcr_link_if.host         link	// Serial link.
);
	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_START = 2'b01,
		H_BITS  = 2'b10,
		H_STOP  = 2'b11
	} mcr_hstate_type;

	typedef struct packed {
		mcr_hstate_type state;
		logic [1:0]     q;
		logic [15:0]    qcnt;
		logic [3:0]     bc;
		logic [1:0]     bidx;
		logic           rd;
		logic [7:0]     regad;
		logic [7:0]     wdat;
		logic [7:0]     rxsh;
		logic [7:0]     rdata;
		logic           nack;
		logic           refused;
		logic           ack_smp;
		logic           scl_oe_n;
		logic           sda_oe_n;
		logic [2:0]     sda_sy;
		logic           sda_f;
		logic [31:0]    prdata;
		logic           pready;
		logic           pslverr;
	} mcr_host_st_type;

	mcr_host_st_type s_r;
	mcr_host_st_type s_nxt;
	logic            qtick;
	logic [7:0]      cur;

	// Byte sent in each slot; a read sets the pointer, then restarts.
	function automatic logic [7:0] byte_at(input mcr_host_st_type s);
		unique case (s.bidx)
			2'd0: return SLV_ADDR_WR;
			2'd1: return s.regad;
			2'd2: return s.rd ? SLV_ADDR_RD : s.wdat;
			2'd3: return 8'hff;
		endcase
	endfunction

	// Next state: APB slave, command start and link sequencer.
	always_comb begin
		s_nxt = s_r;
		s_nxt.sda_sy = {s_r.sda_sy[1:0], link.sda};
		if (s_r.sda_sy[1] == s_r.sda_sy[2]) begin
			s_nxt.sda_f = s_r.sda_sy[2];
		end
		qtick = (s_r.qcnt == 16'(QTR_CYC - 1));
		cur = byte_at(s_r);

		// Zero-wait APB: read data is captured in setup, ready in access.
		s_nxt.pready = psel & ~penable;
		if (psel && !penable) begin
			s_nxt.pslverr = 1'b0;
			unique case (paddr)
				HOFS_CMD:    s_nxt.prdata = {30'h0, s_r.rd, 1'b0};
				HOFS_REG:    s_nxt.prdata = {24'h0, s_r.regad};
				HOFS_WDATA:  s_nxt.prdata = {24'h0, s_r.wdat};
				HOFS_STATUS: s_nxt.prdata = {16'h0, s_r.rdata, 5'h0, s_r.refused,
					s_r.nack, s_r.state != H_IDLE};
				default: begin
					s_nxt.prdata = 32'h0;
					s_nxt.pslverr = 1'b1;
				end
			endcase
		end
		if (psel && penable && s_r.pready && pwrite && !s_r.pslverr && s_r.state == H_IDLE) begin
			if (paddr == HOFS_REG) begin
				s_nxt.regad = pwdata[7:0];
			end
			if (paddr == HOFS_WDATA) begin
				s_nxt.wdat = pwdata[7:0];
			end
			if (paddr == HOFS_CMD && pwdata[CMD_GO_BIT]) begin
				s_nxt.rd = pwdata[CMD_READ_BIT];
				s_nxt.nack = 1'b0;
				s_nxt.refused = 1'b0;
				// Unused codes are refused rather than sent.
				if (!pwdata[CMD_READ_BIT] && s_r.regad == REG_RATE_BIAS &&
					(s_r.wdat[RATE_LSB +: 3] == RATE_UNUSED ||
					s_r.wdat[BIAS_LSB +: 2] == BIAS_UNUSED)) begin
					s_nxt.refused = 1'b1;
				end else begin
					s_nxt.state = H_START;
					s_nxt.q = 2'd0;
					s_nxt.qcnt = 16'h0;
					s_nxt.bidx = 2'd0;
					if (s_r.regad == REG_RATE_BIAS) begin
						s_nxt.wdat = s_r.wdat & RATE_BIAS_MASK;
					end else if (s_r.regad == REG_GAIN) begin
						s_nxt.wdat = s_r.wdat & GAIN_MASK;
					end
				end
			end
		end

		// Each link symbol is four quarters of the serial clock.
		if (s_r.state != H_IDLE) begin
			s_nxt.qcnt = qtick ? 16'h0 : s_r.qcnt + 16'h1;
		end
		if (s_r.state != H_IDLE && qtick) begin
			s_nxt.q = s_r.q + 2'd1;
			unique case (s_r.state)
				H_START: begin
					unique case (s_r.q)
						2'd0: begin
							s_nxt.scl_oe_n = 1'b0;
							s_nxt.sda_oe_n = 1'b1;
						end
						2'd1: s_nxt.scl_oe_n = 1'b1;
						2'd2: s_nxt.sda_oe_n = 1'b0;
						2'd3: begin
							s_nxt.scl_oe_n = 1'b0;
							s_nxt.state = H_BITS;
							s_nxt.bc = 4'h0;
						end
					endcase
				end
				H_BITS: begin
					unique case (s_r.q)
						2'd0: s_nxt.sda_oe_n = (s_r.bc == 4'h8) ? 1'b1 :
							cur[3'(4'd7 - s_r.bc)];
						2'd1: s_nxt.scl_oe_n = 1'b1;
						2'd2: begin
							if (s_r.bc == 4'h8) begin
								s_nxt.ack_smp = s_r.sda_f;
							end else begin
								s_nxt.rxsh = {s_r.rxsh[6:0], s_r.sda_f};
							end
						end
						2'd3: begin
							s_nxt.scl_oe_n = 1'b0;
							s_nxt.bc = s_r.bc + 4'h1;
							if (s_r.bc == 4'h8) begin
								s_nxt.bc = 4'h0;
								s_nxt.bidx = s_r.bidx + 2'd1;
								if (s_r.bidx == 2'd3) begin
									s_nxt.rdata = s_r.rxsh;
									s_nxt.state = H_STOP;
								end else if (s_r.ack_smp) begin
									s_nxt.nack = 1'b1;
									s_nxt.state = H_STOP;
								end else if (s_r.bidx == 2'd1 && s_r.rd) begin
									s_nxt.state = H_START;
								end else if (s_r.bidx == 2'd2 && !s_r.rd) begin
									s_nxt.state = H_STOP;
								end
							end
						end
					endcase
				end
				H_STOP: begin
					unique case (s_r.q)
						2'd0: s_nxt.sda_oe_n = 1'b0;
						2'd1: s_nxt.scl_oe_n = 1'b1;
						2'd2: s_nxt.sda_oe_n = 1'b1;
						2'd3: s_nxt.state = H_IDLE;
					endcase
				end
				H_IDLE: begin
				end
			endcase
		end
	end

	// State register.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			s_r <= '0;
			s_r.scl_oe_n <= 1'b1;
			s_r.sda_oe_n <= 1'b1;
			s_r.sda_sy <= 3'h7;
			s_r.sda_f <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign link.host_scl_oe_n = s_r.scl_oe_n;
	assign link.host_scl_o = 1'b0;
	assign link.host_sda_oe_n = s_r.sda_oe_n;
	assign link.host_sda_o = 1'b0;
endmodule

// ==== verif/mcr_link_properties.sv ====
// Purpose: Timing checks on the serial link between host end and device end.
// Assumes: One clock domain; QTR_CYC equals the host's quarter setting.
// Notes: Sees only interface signals; the bench instantiates it.
module mcr_link_properties #(
	parameter int unsigned QTR_CYC = 5	// Host clock quarter in cycles.
) (
	input wire logic core_clk,		// Core clock.
	input wire logic reset_n,		// Synchronous reset, low.
	input wire logic host_scl_oe_n,	// Host clock enable.
	input wire logic host_scl_o,		// Host clock value.
	input wire logic host_sda_oe_n,	// Host data enable.
	input wire logic host_sda_o,		// Host data value.
	input wire logic dev_sda_oe_n,	// Device data enable.
	input wire logic dev_sda_o,		// Device data value.
	input wire logic scl,			// Resolved clock.
	input wire logic sda			// Resolved data.
);
	int unsigned low_cnt_r;
	int unsigned high_cnt_r;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// Phase lengths of the clock; a short phase would break the device's edge filter.
	always_ff @(posedge core_clk) begin
		low_cnt_r  <= (!reset_n || scl) ? 0 : low_cnt_r + 1;
		high_cnt_r <= (!reset_n || !scl) ? 0 : high_cnt_r + 1;
	end

	scl_drive_zero_a: assert property (!host_scl_oe_n |-> !host_scl_o)
		else $error("host clock driven high");
	host_sda_zero_a: assert property (!host_sda_oe_n |-> !host_sda_o)
		else $error("host data driven high");
	dev_sda_zero_a: assert property (!dev_sda_oe_n |-> !dev_sda_o)
		else $error("device data driven high");
	dev_sda_edge_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
		else $error("device data moved while clock high");
	scl_low_time_a: assert property ($rose(scl) |-> low_cnt_r >= QTR_CYC)
		else $error("clock low phase too short");
	scl_high_time_a: assert property ($fell(scl) |-> high_cnt_r >= QTR_CYC)
		else $error("clock high phase too short");
	start_to_clock_a: assert property ($fell(sda) && scl |-> scl [*4] ##[1:4] !scl)
		else $error("start not followed by clock low");
	stop_release_a: assert property (
			$rose(sda) && scl |-> (host_scl_oe_n && dev_sda_oe_n) [*4])
		else $error("link not released after stop");

	// Main link events.
	cover property ($fell(sda) && scl);
	cover property (!dev_sda_oe_n && $rose(scl));
	cover property ($rose(sda) && scl);
endmodule

// ==== verif/mcr_magnetometer_config_regs_tb.sv ====
// Purpose: Host end and device end joined by the link, driven over APB.
// Assumes: Rate periods shortened by CORE_HZ; quarter of 5 cycles.
// Notes: A wire monitor records address and register bytes per frame.
`define CHK(a, b) begin \
	checks++; \
	if ((a) !== (b)) begin \
		mismatches++; \
		$display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); \
	end \
end
module mcr_magnetometer_config_regs_tb import mcr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned CORE_HZ_TB = 2000;	// Rate periods of 26 to 2666 cycles.
	localparam int unsigned QTR_TB     = 5;	// Shortest quarter above filter delay.
	logic               core_clk = 1'b0;
	logic               reset_n  = 1'b0;
	logic               psel     = 1'b0;
	logic               penable  = 1'b0;
	logic               pwrite   = 1'b0;
	logic [7:0]         paddr    = 8'h00;
	logic [31:0]        pwdata   = 32'h0;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic signed [15:0] meas_x   = 16'h1234;
	logic signed [15:0] meas_y   = 16'h8000;
	logic signed [15:0] meas_z   = 16'h0123;
	logic [2:0]         output_rate_sel;
	logic [2:0]         gain_sel;
	logic [1:0]         bias_meas_sel;
	logic               bias_pos_en;
	logic               bias_neg_en;
	logic               result_tick;
	logic [7:0]         sh = 8'h00;
	logic [7:0]         addr_seen = 8'h00;
	logic [7:0]         reg_seen = 8'h00;
	logic               scl_q = 1'b1;
	logic               sda_q = 1'b1;
	int                 bitn = 0;
	int                 mismatches = 0;
	int                 checks = 0;
	logic [7:0]         res_exp [6] = '{8'h07, 8'hff, 8'hf8, 8'h00, 8'h01, 8'h23};

	mcr_link_if link_i ();
	mcr_host #(.QTR_CYC(QTR_TB)) mcr_host_i (.core_clk(core_clk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_i.host));
	mcr_dev #(.CORE_HZ(CORE_HZ_TB)) mcr_dev_i (.core_clk(core_clk), .reset_n(reset_n),
		.link(link_i.dev), .meas_x(meas_x), .meas_y(meas_y), .meas_z(meas_z),
		.output_rate_sel(output_rate_sel), .bias_meas_sel(bias_meas_sel), .gain_sel(gain_sel),
		.bias_pos_en(bias_pos_en), .bias_neg_en(bias_neg_en), .result_tick(result_tick));
	mcr_link_properties #(.QTR_CYC(QTR_TB)) mcr_link_properties_i (.core_clk(core_clk),
		.reset_n(reset_n), .host_scl_oe_n(link_i.host_scl_oe_n), .host_scl_o(link_i.host_scl_o),
		.host_sda_oe_n(link_i.host_sda_oe_n), .host_sda_o(link_i.host_sda_o),
		.dev_sda_oe_n(link_i.dev_sda_oe_n), .dev_sda_o(link_i.dev_sda_o),
		.scl(link_i.scl), .sda(link_i.sda));

	// Clock of 50 ns.
	initial begin
		forever #25 core_clk = ~core_clk;
	end

	// Wire monitor: bits are taken at rising clock, so the read address byte 3Dh proves the bit order; 3Ch reads the same either way.
	always @(posedge core_clk) begin
		scl_q <= link_i.scl;
		sda_q <= link_i.sda;
		if (scl_q && link_i.scl && sda_q && !link_i.sda) begin
			bitn <= 0;
		end else if (!scl_q && link_i.scl) begin
			sh <= {sh[6:0], link_i.sda};
			bitn <= bitn + 1;
			if (bitn == 7) addr_seen <= {sh[6:0], link_i.sda};
			if (bitn == 16) reg_seen <= {sh[6:0], link_i.sda};
		end
	end

	// One APB transfer; entered just after an edge, leaves one edge after release.
	// No local limit on the wait: a slave that never answers is left to the watchdog.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	// One link command, then polling of the status until busy drops.
	task automatic dev_cmd(input logic rd, input logic [7:0] r, input logic [7:0] d,
			output logic [31:0] st);
		logic [31:0] q;
		logic        e;
		int          n;
		apb(1'b1, HOFS_REG, {24'h0, r}, q, e);
		apb(1'b1, HOFS_WDATA, {24'h0, d}, q, e);
		apb(1'b1, HOFS_CMD, {30'h0, rd, 1'b1}, q, e);
		n = 0;
		do begin
			apb(1'b0, HOFS_STATUS, 32'h0, st, e);
			n++;
		end while (st[0] !== 1'b0 && n < 500);
		`CHK({st[0], st[1]}, 2'b00)
	endtask

	// Cycles to the next result pulse.
	task automatic wait_tick(output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (result_tick !== 1'b1 && n < 3000);
	endtask

	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Main sequence: defaults, bias codes, gains, refusals, rates, results.
	initial begin
		logic [31:0] q;
		logic [31:0] st;
		logic        e;
		int          p;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge core_clk);
		`CHK({output_rate_sel, bias_meas_sel, gain_sel}, 8'h81)
		apb(1'b0, 8'h10, 32'h0, q, e);
		`CHK({e, q}, 33'h100000000)
		apb(1'b1, HOFS_WDATA, 32'h0000_00a5, q, e);
		apb(1'b0, HOFS_WDATA, 32'h0, q, e);
		`CHK({e, q}, 33'ha5)
		for (int b = 0; b < 3; b++) begin
			dev_cmd(1'b0, REG_RATE_BIAS, 8'hf8 | 8'(b), st);
			`CHK(addr_seen, SLV_ADDR_WR)
			`CHK(reg_seen, REG_RATE_BIAS)
			`CHK({bias_meas_sel, bias_pos_en, bias_neg_en}, {2'(b), b == 1, b == 2})
			`CHK(output_rate_sel, 3'h6)
			dev_cmd(1'b1, REG_RATE_BIAS, 8'h00, st);
			`CHK(addr_seen, SLV_ADDR_RD)
			`CHK(st[15:8], 8'h18 | 8'(b))
		end
		for (int g = 1; g < 8; g++) begin
			dev_cmd(1'b0, REG_GAIN, {3'(g), 5'h1f}, st);
			`CHK(gain_sel, 3'(g))
			dev_cmd(1'b1, REG_GAIN, 8'h00, st);
			`CHK(st[15:8], {3'(g), 5'h00})
		end
		dev_cmd(1'b0, REG_RATE_BIAS, 8'h1c, st);
		`CHK(st[2], 1'b1)
		dev_cmd(1'b0, REG_RATE_BIAS, 8'h03, st);
		`CHK({st[2], bias_meas_sel}, 3'h6)
		dev_cmd(1'b0, 8'h02, 8'h00, st);
		`CHK({output_rate_sel, gain_sel}, 6'h37)
		for (int c = 0; c < 7; c++) begin
			dev_cmd(1'b0, REG_RATE_BIAS, {3'h0, 3'(c), 2'h0}, st);
			wait_tick(p);
			wait_tick(p);
			`CHK(p, int'(CORE_HZ_TB * 1000 / RATE_MILLIHZ[c]))
		end
		for (int i = 0; i < 6; i++) begin
			dev_cmd(1'b1, REG_OUT_XH + 8'(i), 8'h00, st);
			`CHK(st[15:8], res_exp[i])
		end
		complete_run();
	end

	// Watchdog: about twice the expected run.
	initial begin
		repeat (80000) @(posedge core_clk);
		mismatches++;
		complete_run();
	end
endmodule
